// File: design/tdm_access_map.sv
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module tdm_access_map (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  // host port
  tdm_host_port_if.device  hostPort,
  // received timeslot bits, one at a time
  input  wire logic        bitValid,
  output logic             bitReady,
  input  wire logic        bitBackplane,
  input  wire logic [4:0]  bitStream,
  input  wire logic [8:0]  bitChannel,
  input  wire logic        bitData,
  // side runs at the top rate
  input  wire logic        localFast,
  input  wire logic        backplaneFast,
  // connection memory port
  output logic             cmStrobe,
  output logic             cmBackplane,
  output logic             cmWrite,
  output logic [13:0]      cmAddr,
  output logic [15:0]      cmWdata,
  input  wire logic [15:0] cmRdata,
  input  wire logic        cmAck,
  // status
  output logic [2:0]       selectedMemory
);
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_CONN = 1'b1
  } access_phase_t;

  typedef struct packed {
    logic [tdm_map_pkg::LOCAL_DEPTH-1:0][7:0] localStore;
    logic [tdm_map_pkg::BACK_DEPTH-1:0][7:0]  backStore;
    logic [1:0][7:0]                          shift;
    logic [1:0][2:0]                          bitCount;
    tdm_map_pkg::mem_select_t                 memorySelect;
    access_phase_t                            phase;
    logic                                     ack;
    logic [15:0]                              rdata;
    logic                                     cmStrobe;
    logic                                     cmBackplane;
    logic                                     cmWrite;
    logic [13:0]                              cmAddr;
    logic [15:0]                              cmWdata;
  } device_state_t;

  device_state_t                    s;
  device_state_t                    next_s;
  logic                             side;
  logic [7:0]                       pushByte;
  logic [12:0]                      pushIndex;
  logic [tdm_map_pkg::ENTRY_W-1:0]  pushData;
  logic                             pushValid;
  logic                             pushReady;
  logic [tdm_map_pkg::ENTRY_W-1:0]  drainData;
  logic                             drainValid;
  logic                             drainReady;
  logic                             hostTake;
  logic                             hostBack;
  logic [4:0]                       hostStream;
  logic [8:0]                       hostChannel;
  logic [12:0]                      hostIndex;
  logic                             entrySide;
  logic [12:0]                      entryIndex;
  logic [7:0]                       entryByte;

  assign entrySide  = drainData[tdm_map_pkg::ENTRY_SIDE_BIT];
  assign entryIndex = drainData[tdm_map_pkg::ENTRY_IDX_LSB +:
                                tdm_map_pkg::BACK_IDX_W];
  assign entryByte  = drainData[tdm_map_pkg::BYTE_W-1:0];

  // completed bytes wait here while the host holds the stores
  tdm_byte_fifo #(
    .WIDTH (tdm_map_pkg::ENTRY_W),
    .DEPTH (tdm_map_pkg::FIFO_DEPTH)
  ) byteQueue (
    .clock    (clock),
    .rst_n    (rst_n),
    .enable   (enable),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (drainData)
  );

  // a full queue stalls the bit source
  assign bitReady = pushReady;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    // serial to parallel, per side
    side = bitBackplane;
    pushByte = {s.shift[side][6:0], bitData};
    pushIndex = tdm_map_pkg::store_index(side,
                                         side ? backplaneFast : localFast,
                                         bitStream, bitChannel);
    pushData = {side, pushIndex, pushByte};
    pushValid = bitValid && (s.bitCount[side] == tdm_map_pkg::LAST_BIT);
    if (bitValid && bitReady) begin
      next_s.shift[side] = pushByte;
      next_s.bitCount[side] = s.bitCount[side] + 1'b1;
    end
    // host address decode
    hostTake = (s.phase == PH_IDLE) && hostPort.req && !s.ack;
    hostBack = (s.memorySelect == tdm_map_pkg::MSEL_BACK_DATA);
    hostStream = hostPort.addr[tdm_map_pkg::STREAM_LO +:
                               tdm_map_pkg::STREAM_W];
    hostChannel = hostPort.addr[tdm_map_pkg::CHAN_W-1:0];
    hostIndex = tdm_map_pkg::store_index(hostBack,
                                         hostBack ? backplaneFast : localFast,
                                         hostStream, hostChannel);
    // store writes yield to a host access in the same cycle
    drainReady = !hostTake;
    if (drainValid && drainReady) begin
      if (entrySide) begin
        next_s.backStore[entryIndex] = entryByte;
      end else begin
        next_s.localStore[entryIndex[tdm_map_pkg::LOCAL_IDX_W-1:0]] =
          entryByte;
      end
    end
    unique case (s.phase)
      PH_IDLE: begin
        if (hostTake) begin
          next_s.ack = 1'b1;
          next_s.rdata = '0;
          if (!hostPort.addr[tdm_map_pkg::SPACE_BIT]) begin
            if (hostPort.addr[tdm_map_pkg::LOC_W-1:0] ==
                tdm_map_pkg::CTRL_REG_ADDR) begin
              if (hostPort.we) begin
                next_s.memorySelect = tdm_map_pkg::mem_select_t'(
                  hostPort.wdata[tdm_map_pkg::MSEL_LSB +:
                                 tdm_map_pkg::MSEL_W]);
              end else begin
                next_s.rdata = {13'h0000, s.memorySelect};
              end
            end
          end else begin
            case (s.memorySelect)
              tdm_map_pkg::MSEL_LOCAL_CONN,
              tdm_map_pkg::MSEL_BACK_CONN: begin
                next_s.ack = 1'b0;
                next_s.phase = PH_CONN;
                next_s.cmStrobe = 1'b1;
                next_s.cmBackplane = (s.memorySelect ==
                  tdm_map_pkg::MSEL_BACK_CONN);
                next_s.cmWrite = hostPort.we;
                next_s.cmAddr = hostPort.addr[tdm_map_pkg::LOC_W-1:0];
                next_s.cmWdata = hostPort.wdata;
              end
              tdm_map_pkg::MSEL_LOCAL_DATA: begin
                // writes only acknowledge
                if (!hostPort.we) begin
                  next_s.rdata = {tdm_map_pkg::UPPER_ZERO,
                    s.localStore[hostIndex[tdm_map_pkg::LOCAL_IDX_W-1:0]]};
                end
              end
              tdm_map_pkg::MSEL_BACK_DATA: begin
                if (!hostPort.we) begin
                  next_s.rdata = {tdm_map_pkg::UPPER_ZERO,
                                  s.backStore[hostIndex]};
                end
              end
              default: begin
                next_s.rdata = '0;
              end
            endcase
          end
        end
      end
      PH_CONN: begin
        if (cmAck) begin
          next_s.ack = 1'b1;
          next_s.rdata = s.cmWrite ? '0 : cmRdata;
          next_s.cmStrobe = 1'b0;
          next_s.phase = PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.memorySelect <= tdm_map_pkg::mem_select_t'(tdm_map_pkg::CTRL_RESET);
    end else if (enable) begin
      s <= next_s;
    end
  end

  assign hostPort.ack   = s.ack;
  assign hostPort.rdata = s.rdata;
  assign cmStrobe       = s.cmStrobe;
  assign cmBackplane    = s.cmBackplane;
  assign cmWrite        = s.cmWrite;
  assign cmAddr         = s.cmAddr;
  assign cmWdata        = s.cmWdata;
  assign selectedMemory = s.memorySelect;
endmodule

// File: design/tdm_map_pkg.sv
// Notes on behaviour
// - top address bit high selects memory space
// - memory select field routes to four memories
// - address bits 13 to 9 give stream
// - host limits streams at top rate
// - address bits 8 to 0 give channel
// - host addresses only channels valid for rate
// - serial bits become bytes stored per side
// - local byte store holds 4096 positions
// - backplane byte store holds 8192 positions
// - byte stores read only, latest byte returned
// - byte store reads zero upper eight bits
// - first received bit lands in bit 7
// - code 000 selects local connection memory
// - code 001 selects backplane connection memory
package tdm_map_pkg;
  // host port address layout
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 16;
  localparam int SPACE_BIT = 14;
  localparam int STREAM_LO = 9;
  localparam int STREAM_W  = 5;
  localparam int CHAN_W    = 9;
  localparam int LOC_W     = 14;
  // register space
  localparam logic [13:0] CTRL_REG_ADDR = 14'h0000;
  localparam int          MSEL_LSB      = 0;
  localparam int          MSEL_W        = 3;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  // byte stores
  localparam int         LOCAL_DEPTH = 4096;
  localparam int         BACK_DEPTH  = 8192;
  localparam int         LOCAL_IDX_W = 12;
  localparam int         BACK_IDX_W  = 13;
  localparam int         BYTE_W      = 8;
  localparam logic [7:0] UPPER_ZERO  = 8'h00;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  // fifo entry: side, index, byte
  localparam int FIFO_DEPTH     = 8;
  localparam int ENTRY_W        = 22;
  localparam int ENTRY_SIDE_BIT = 21;
  localparam int ENTRY_IDX_LSB  = 8;
  // host-side legality limits
  localparam logic [2:0] RATE_TOP           = 3'h4;
  localparam logic [9:0] BASE_CHANNELS      = 10'h020;
  localparam logic [5:0] LOCAL_STREAM_COUNT = 6'h10;
  localparam logic [5:0] BACK_STREAM_COUNT  = 6'h20;
  // wishbone register offsets of the host end
  localparam int         WB_ADR_W  = 8;
  localparam logic [7:0] HR_ADDR   = 8'h00;
  localparam logic [7:0] HR_WDATA  = 8'h04;
  localparam logic [7:0] HR_CMD    = 8'h08;
  localparam logic [7:0] HR_STATUS = 8'h0c;
  localparam logic [7:0] HR_RDATA  = 8'h10;
  localparam logic [7:0] HR_LIMIT  = 8'h14;
  localparam int CMD_GO     = 0;
  localparam int CMD_WRITE  = 1;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_REFUSED = 2;
  localparam int LIM_RATE   = 0;
  localparam int LIM_SIDE   = 3;
  localparam int LIM_CHECK  = 4;
  localparam int LIM_W      = 5;

  typedef enum logic [2:0] {
    MSEL_LOCAL_CONN = 3'b000,
    MSEL_BACK_CONN  = 3'b001,
    MSEL_LOCAL_DATA = 3'b010,
    MSEL_BACK_DATA  = 3'b011
  } mem_select_t;

  // position in a byte store from stream and channel
  function automatic logic [12:0] store_index(
    input logic       backplane,
    input logic       fast,
    input logic [4:0] stream,
    input logic [8:0] channel
  );
    logic [12:0] idx;
    idx = 13'h0000;
    if (backplane && fast) begin
      idx = {stream[3:0], channel[8:0]};
    end else if (backplane) begin
      idx = {stream[4:0], channel[7:0]};
    end else if (fast) begin
      idx = {1'b0, stream[2:0], channel[8:0]};
    end else begin
      idx = {1'b0, stream[3:0], channel[7:0]};
    end
    return idx;
  endfunction
endpackage

// File: design/tdm_host_port_if.sv
`timescale 1ns/1ps
interface tdm_host_port_if (
  input wire logic clock
);
  logic        req;
  logic        we;
  logic [14:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;

  modport device (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output rdata,
    output ack
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  rdata,
    input  ack
  );
endinterface

// File: design/tdm_byte_fifo.sv
`timescale 1ns/1ps
module tdm_byte_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             enable,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PTR_W-1:0]            wrPtr;
    logic [PTR_W-1:0]            rdPtr;
    logic [PTR_W:0]              count;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t next_s;
  logic        push;
  logic        pop;

  assign inReady  = enable && (s.count != (PTR_W+1)'(DEPTH));
  assign outValid = (s.count != '0);
  assign outData  = s.slot[s.rdPtr];

  always_comb begin
    next_s = s;
    push = inValid && inReady;
    pop  = outValid && outReady && enable;
    if (push) begin
      next_s.slot[s.wrPtr] = inData;
      next_s.wrPtr = (s.wrPtr == PTR_W'(DEPTH - 1)) ? '0 : s.wrPtr + 1'b1;
    end
    if (pop) begin
      next_s.rdPtr = (s.rdPtr == PTR_W'(DEPTH - 1)) ? '0 : s.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (enable) begin
      s <= next_s;
    end
  end
endmodule

// File: design/tdm_host_master.sv
`timescale 1ns/1ps
module tdm_host_master (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic [31:0]      wbDatO,
  output logic             wbAck,
  // device port
  tdm_host_port_if.host    busPort
);
  typedef struct packed {
    logic [14:0] addrReg;
    logic [15:0] wdataReg;
    logic [15:0] rdataReg;
    logic [4:0]  limit;
    logic        busy;
    logic        done;
    logic        refused;
    logic        wbAck;
    logic [31:0] wbDatO;
    logic        req;
    logic        we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic        take;
  logic [31:0] mask;
  logic [31:0] readWord;
  logic [31:0] oldWord;
  logic [31:0] merged;
  logic [2:0]  rate;
  logic [9:0]  chanCount;
  logic [5:0]  streamCount;
  logic        legal;
  logic        go;

  always_comb begin
    next_s = s;
    take = wbCyc && wbStb && !s.wbAck;
    mask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
    // legality of the pending address against the programmed rate
    rate = s.limit[tdm_map_pkg::LIM_RATE +: 3];
    if (rate > tdm_map_pkg::RATE_TOP) begin
      rate = tdm_map_pkg::RATE_TOP;
    end
    chanCount = tdm_map_pkg::BASE_CHANNELS << rate;
    streamCount = s.limit[tdm_map_pkg::LIM_SIDE] ?
                  tdm_map_pkg::BACK_STREAM_COUNT :
                  tdm_map_pkg::LOCAL_STREAM_COUNT;
    if (rate == tdm_map_pkg::RATE_TOP) begin
      streamCount = streamCount >> 1;
    end
    legal = !s.limit[tdm_map_pkg::LIM_CHECK] ||
            !s.addrReg[tdm_map_pkg::SPACE_BIT] ||
            (({1'b0, s.addrReg[8:0]} < chanCount) &&
             ({1'b0, s.addrReg[13:9]} < streamCount));
    readWord = 32'h00000000;
    unique case (wbAdr)
      tdm_map_pkg::HR_ADDR:   readWord = {17'h00000, s.addrReg};
      tdm_map_pkg::HR_WDATA:  readWord = {16'h0000, s.wdataReg};
      tdm_map_pkg::HR_CMD:    readWord = {30'h00000000, s.we, 1'b0};
      tdm_map_pkg::HR_STATUS: readWord = {29'h00000000, s.refused,
                                          s.done, s.busy};
      tdm_map_pkg::HR_RDATA:  readWord = {16'h0000, s.rdataReg};
      tdm_map_pkg::HR_LIMIT:  readWord = {27'h0000000, s.limit};
      default:                readWord = 32'h00000000;
    endcase
    oldWord = wbWe ? readWord : 32'h00000000;
    merged = (oldWord & ~mask) | (wbDatI & mask);
    next_s.wbAck = take;
    next_s.wbDatO = (take && !wbWe) ? readWord : 32'h00000000;
    go = 1'b0;
    if (take && wbWe) begin
      unique case (wbAdr)
        tdm_map_pkg::HR_ADDR:  next_s.addrReg = merged[14:0];
        tdm_map_pkg::HR_WDATA: next_s.wdataReg = merged[15:0];
        tdm_map_pkg::HR_LIMIT: next_s.limit = merged[4:0];
        tdm_map_pkg::HR_CMD:   go = wbSel[0] && wbDatI[tdm_map_pkg::CMD_GO];
        tdm_map_pkg::HR_STATUS: begin
          if (wbSel[0] && wbDatI[tdm_map_pkg::ST_DONE]) begin
            next_s.done = 1'b0;
          end
          if (wbSel[0] && wbDatI[tdm_map_pkg::ST_REFUSED]) begin
            next_s.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (go && !s.busy) begin
      if (legal) begin
        next_s.busy = 1'b1;
        next_s.req = 1'b1;
        next_s.we = wbDatI[tdm_map_pkg::CMD_WRITE];
        next_s.addr = s.addrReg;
        next_s.wdata = s.wdataReg;
      end else begin
        next_s.refused = 1'b1;
      end
    end
    // completion sets done after any clear in the same cycle
    if (s.req && busPort.ack) begin
      next_s.req = 1'b0;
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      if (!s.we) begin
        next_s.rdataReg = busPort.rdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (enable) begin
      s <= next_s;
    end
  end

  assign wbAck         = s.wbAck;
  assign wbDatO        = s.wbDatO;
  assign busPort.req   = s.req;
  assign busPort.we    = s.we;
  assign busPort.addr  = s.addr;
  assign busPort.wdata = s.wdata;
endmodule

// File: bench/tdm_access_map_checker.sv
`timescale 1ns/1ps
module tdm_access_map_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // host port
  input wire logic        req,
  input wire logic        we,
  input wire logic [14:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack
);
  logic [2:0] msel;
  logic       store;

  // mirror of the memory select field
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msel <= 3'h0;
    end else if (ack && we && !addr[14] && addr[13:0] == 14'h0) begin
      msel <= wdata[2:0];
    end
  end
  assign store = msel == 3'h2 || msel == 3'h3;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_ack_single: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  a_ack_with_req: assert property (ack |-> req)
    else $error("ack without a pending request");
  a_req_released: assert property (ack |=> !req)
    else $error("request not released after ack");
  a_reg_answer: assert property ($rose(req) && !addr[14] |=> ack)
    else $error("register access not answered in one cycle");
  a_store_answer: assert property (
    $rose(req) && addr[14] && store |=> ack)
    else $error("byte store access not answered in one cycle");
  a_conn_answer: assert property (
    $rose(req) && addr[14] && msel[2:1] == 2'h0 |=> !ack ##[1:40] ack)
    else $error("connection memory access answer out of bounds");
  a_upper_zero: assert property (
    ack && addr[14] && !we && store |-> rdata[15:8] == 8'h00)
    else $error("byte store read upper half not zero");
  a_store_write_quiet: assert property (
    ack && addr[14] && we && store |-> rdata == 16'h0000)
    else $error("byte store write returned data");
  a_unused_zero: assert property (
    ack && addr[14] && msel[2] |-> rdata == 16'h0000)
    else $error("unused select code returned data");
  a_ctrl_readback: assert property (
    ack && !addr[14] && !we && addr[13:0] == 14'h0 |-> rdata[2:0] == msel)
    else $error("control readback differs from select field");
  a_reg_reserved: assert property (
    ack && !addr[14] && !we && addr[13:0] != 14'h0 |-> rdata == 16'h0000)
    else $error("unused register read not zero");
endmodule

// File: bench/tdm_switch_memory_access_map_bench.sv
`timescale 1ns/1ps
module tdm_switch_memory_access_map_bench;
  logic        clock, rst_n, enable, wbCyc, wbStb, wbWe, wbAck, cmAck;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, st, q, d0;
  logic        bitValid, bitReady, bitBackplane, bitData;
  logic [4:0]  bitStream;
  logic [8:0]  bitChannel;
  logic        localFast, backplaneFast, cmStrobe, cmBackplane, cmWrite;
  logic [13:0] cmAddr;
  logic [15:0] cmWdata, cmRdata, cmLast;
  logic [2:0]  selectedMemory;
  logic [3:0]  cmWait, cmDelay;
  int          err_count, n_tests, cyc, i, k;
  logic [31:0] limTab [6] = '{32'h10, 32'h10, 32'h14, 32'h14, 32'h1c, 32'h1c};
  logic [4:0]  sTab [6]   = '{5'h00, 5'h00, 5'h08, 5'h07, 5'h10, 5'h0f};
  logic [8:0]  cTab [6]   = '{9'h020, 9'h01f, 9'h000, 9'h000, 9'h000, 9'h000};

  tdm_host_port_if busIf (.clock(clock));
  tdm_access_map u_tdm_access_map (.clock(clock), .rst_n(rst_n),
    .enable(enable), .hostPort(busIf), .bitValid(bitValid),
    .bitReady(bitReady), .bitBackplane(bitBackplane),
    .bitStream(bitStream), .bitChannel(bitChannel), .bitData(bitData),
    .localFast(localFast), .backplaneFast(backplaneFast),
    .cmStrobe(cmStrobe), .cmBackplane(cmBackplane), .cmWrite(cmWrite),
    .cmAddr(cmAddr), .cmWdata(cmWdata), .cmRdata(cmRdata), .cmAck(cmAck),
    .selectedMemory(selectedMemory));
  tdm_host_master u_tdm_host_master (.clock(clock), .rst_n(rst_n),
    .enable(enable), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .busPort(busIf));
  tdm_access_map_checker u_tdm_access_map_checker (.clock(clock),
    .rst_n(rst_n), .req(busIf.req), .we(busIf.we), .addr(busIf.addr),
    .wdata(busIf.wdata), .rdata(busIf.rdata), .ack(busIf.ack));

  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  // connection memory responder, answer cmDelay+1 cycles after the strobe rises
  always @(posedge clock) begin
    cyc <= cyc + 1;
    cmWait <= (cmStrobe && !cmAck) ? cmWait + 4'h1 : 4'h0;
    cmAck <= cmStrobe && !cmAck && cmWait >= cmDelay;
    cmRdata <= cmStrobe ? {1'h1, cmBackplane, cmAddr} : ~cmRdata;
    if (cmStrobe && cmAck && cmWrite) cmLast <= cmWdata;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] r);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do begin
      @(posedge clock);
    end while (wbAck !== 1'h1);
    r = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    @(posedge clock);
  endtask

  // one device access through the host end's registers
  task dev(input logic w, input logic [14:0] a, input logic [15:0] d);
    wb(1'h1, tdm_map_pkg::HR_ADDR, {17'h0, a}, d0);
    wb(1'h1, tdm_map_pkg::HR_WDATA, {16'h0, d}, d0);
    wb(1'h1, tdm_map_pkg::HR_CMD, {30'h0, w, 1'h1}, d0);
    do begin
      wb(1'h0, tdm_map_pkg::HR_STATUS, 32'h0, st);
    end while (st[2:1] == 2'h0);
    wb(1'h0, tdm_map_pkg::HR_RDATA, 32'h0, q);
    wb(1'h1, tdm_map_pkg::HR_STATUS, 32'h6, d0);
  endtask

  task sel(input logic [2:0] code);
    dev(1'h1, 15'h0000, {13'h0, code});
    chk({29'h0, selectedMemory}, {29'h0, code});
  endtask

  // one timeslot byte, first bit sent is byte bit 7
  task sb(input logic side, input logic [4:0] s, input logic [8:0] c,
          input logic [7:0] b);
    int j;
    for (j = 7; j >= 0; j--) begin
      bitValid <= 1'h1;
      bitBackplane <= side;
      bitStream <= s;
      bitChannel <= c;
      bitData <= b[j];
      do begin
        @(posedge clock);
      end while (bitReady !== 1'h1);
    end
    bitValid <= 1'h0;
    @(posedge clock);
  endtask

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    {rst_n, wbCyc, wbStb, wbWe, bitValid, bitBackplane, bitData} = 7'h0;
    {localFast, backplaneFast, cmAck} = 3'h0;
    {wbAdr, wbDatI, bitStream, bitChannel} = 54'h0;
    {cmWait, cmDelay, cmRdata, cmLast} = 40'h0;
    enable = 1'h1;
    wbSel = 4'hf;
    cyc = 0;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    chk({29'h0, selectedMemory}, 32'h0);
    wb(1'h0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    dev(1'h0, 15'h0000, 16'h0000);
    chk(q, 32'h0);
    dev(1'h0, 15'h0005, 16'h0000);
    chk(q, 32'h0);
    for (k = 0; k < 2; k++) begin
      cmDelay <= k * 3;
      sel(k);
      dev(1'h0, {1'h1, 5'h11, 9'h12c}, 16'h0000);
      chk(q, {16'h0, 1'h1, k[0], 5'h11, 9'h12c});
      dev(1'h1, {1'h1, 5'h02, 9'h009}, 16'hbe00 + k);
      chk({16'h0, cmLast}, 32'hbe00 + k);
    end
    sb(1'h0, 5'h03, 9'h005, 8'ha5);
    sb(1'h1, 5'h14, 9'h0c8, 8'h3c);
    sb(1'h1, 5'h1f, 9'h0ff, 8'hc3);
    localFast <= 1'h1;
    sb(1'h0, 5'h07, 9'h1ff, 8'h81);
    sel(3'h2);
    dev(1'h0, {1'h1, 5'h07, 9'h1ff}, 16'h0000);
    chk(q, 32'h81);
    localFast <= 1'h0;
    dev(1'h0, {1'h1, 5'h03, 9'h005}, 16'h0000);
    chk(q, 32'ha5);
    dev(1'h1, {1'h1, 5'h03, 9'h005}, 16'hffff);
    dev(1'h0, {1'h1, 5'h03, 9'h005}, 16'h0000);
    chk(q, 32'ha5);
    sb(1'h0, 5'h03, 9'h005, 8'h5a);
    dev(1'h0, {1'h1, 5'h03, 9'h005}, 16'h0000);
    chk(q, 32'h5a);
    sel(3'h3);
    dev(1'h0, {1'h1, 5'h14, 9'h0c8}, 16'h0000);
    chk(q, 32'h3c);
    dev(1'h0, {1'h1, 5'h1f, 9'h0ff}, 16'h0000);
    chk(q, 32'hc3);
    sel(3'h4);
    dev(1'h0, {1'h1, 5'h01, 9'h001}, 16'h0000);
    chk(q, 32'h0);
    sel(3'h2);
    for (k = 0; k < 6; k++) begin
      wb(1'h1, tdm_map_pkg::HR_LIMIT, limTab[k], d0);
      dev(1'h0, {1'h1, sTab[k], cTab[k]}, 16'h0000);
      chk({31'h0, st[2]}, {31'h0, ~k[0]});
    end
    wb(1'h1, tdm_map_pkg::HR_LIMIT, 32'h0, d0);
    // a run of bytes through the store queue, then read each back
    sel(3'h3);
    for (i = 0; i < 8; i++) begin
      sb(1'h1, 5'h01, i[8:0], 8'h30 + i);
      chk({31'h0, bitReady}, 32'h1);
    end
    for (i = 0; i < 8; i++) begin
      dev(1'h0, {1'h1, 5'h01, i[8:0]}, 16'h0000);
      chk(q, 32'h30 + i);
    end
    // reset in mid-run clears the select field and the stores
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    chk({29'h0, selectedMemory}, 32'h0);
    sel(3'h3);
    dev(1'h0, {1'h1, 5'h01, 9'h003}, 16'h0000);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule
